// file: core/alarm_defs.svh
// Register offsets, field positions and reset values of the alarm block
`ifndef ALARM_DEFS_SVH
`define ALARM_DEFS_SVH
`define SUMMARY_IDX 12'h2c0
`define FLAGS_IDX 12'h2c1
`define MASK_IDX 12'h2c2
`define LANE_IDX 12'h2c4
`define CTRL_IDX 12'h2c8
`define FLAGS_RESET 8'h3f
`define MASK_RESET 8'h3f
`define LANE_RESET 8'hff
`define CTRL_RESET 8'h00
`define BIT_DIV 0
`define BIT_RSV1 1
`define BIT_REALIGN 2
`define BIT_LINK 3
`define BIT_PLL 4
`define BIT_FIFO 5
`define ALARM_BITS 8'h3d
`define CTRL_BIT_SOFT_RESET 0
`define CTRL_BIT_PIN_SEL 1
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// file: core/alarm_pkg.sv
// Types shared by the alarm block
package alarm_pkg;
  typedef struct packed {
    logic link_enable;
    logic mode_64b66b;
    logic in_payload_state;
    logic link_start;
    logic serializer_realign;
    logic clock_realign;
    logic divider_mismatch;
    logic pll_unlock;
  } alarm_events_t;
  typedef enum logic [1:0] {W_IDLE, W_RESP} wr_state_t;
  typedef enum logic [1:0] {R_IDLE, R_RESP} rd_state_t;
endpackage : alarm_pkg

// file: core/alarm_status_aggregator.sv
// Alarm flag collection with mask, summary output and AXI4-Lite registers
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`include "alarm_defs.svh"
module alarm_status_aggregator #(
  parameter int LANES = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire alarm_pkg::alarm_events_t i_events,
  input wire logic [LANES-1:0] i_lane_fifo_error,
  input wire logic [LANES-1:0] i_lane_active,
  input wire logic i_cal_status,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [31:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_irq,
  output logic o_cal_status_pin
);
  import alarm_pkg::*;

  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [LANES-1:0] lane_reg;
  logic [LANES-1:0] lane_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic aw_got_reg;
  logic aw_got_next;
  logic w_got_reg;
  logic w_got_next;
  logic [31:0] awaddr_reg;
  logic [31:0] awaddr_next;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_next;
  logic [3:0] wstrb_reg;
  logic [3:0] wstrb_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic link_en_d_reg;
  logic link_en_d_next;
  logic flags_wr;
  logic mask_wr;
  logic lane_wr;
  logic ctrl_wr;
  wr_state_t wst_reg, wst_next;
  rd_state_t rst_reg, rst_next;
  logic wr_fire;
  logic [7:0] wr_byte;
  logic [11:0] wr_idx;
  logic [11:0] rd_idx;
  logic [7:0] set_vec;
  logic [LANES-1:0] lane_set;
  logic summary;
  logic soft_reset;

  // Channel readies
  assign o_awready = (wst_reg == W_IDLE) && !aw_got_reg;
  assign o_wready = (wst_reg == W_IDLE) && !w_got_reg;
  assign o_arready = (rst_reg == R_IDLE);
  assign o_bvalid = (wst_reg == W_RESP);
  assign o_bresp = bresp_reg;

  // Read channel outputs
  assign o_rvalid = (rst_reg == R_RESP);
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;

  // Address decode and write launch
  assign wr_idx = awaddr_reg[13:2];
  assign rd_idx = i_araddr[13:2];
  assign wr_byte = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;
  assign wr_fire = (wst_reg == W_IDLE) && aw_got_reg && w_got_reg;
  assign soft_reset = ctrl_reg[`CTRL_BIT_SOFT_RESET];

  // Hardware set conditions
  always_comb begin
    set_vec = 8'h00;
    lane_set = i_lane_fifo_error & i_lane_active;
    if (!i_events.mode_64b66b) begin
      set_vec[`BIT_LINK] = i_events.link_enable && !i_events.in_payload_state;
    end else begin
      set_vec[`BIT_LINK] = i_events.link_start || i_events.serializer_realign ||
          (i_events.link_enable && !link_en_d_reg);
    end
    set_vec[`BIT_REALIGN] = i_events.clock_realign;
    set_vec[`BIT_DIV] = i_events.divider_mismatch;
    set_vec[`BIT_FIFO] = |lane_set;
    set_vec[`BIT_PLL] = i_events.pll_unlock;
  end

  // Summary of unmasked flags
  assign summary = |(flags_reg & ~mask_reg & `ALARM_BITS);
  assign o_irq = summary;
  assign o_cal_status_pin = ctrl_reg[`CTRL_BIT_PIN_SEL] ? summary : i_cal_status;

  // Register write strobes, byte lane 0 only
  assign flags_wr = wr_fire && wstrb_reg[0] && (wr_idx == `FLAGS_IDX);
  assign mask_wr = wr_fire && wstrb_reg[0] && (wr_idx == `MASK_IDX);
  assign lane_wr = wr_fire && wstrb_reg[0] && (wr_idx == `LANE_IDX);
  assign ctrl_wr = wr_fire && wstrb_reg[0] && (wr_idx == `CTRL_IDX);

  // Alarm flag next state
  always_comb begin
    flags_next = flags_reg;
    if (flags_wr) begin
      flags_next = flags_reg & ~(wr_byte & `ALARM_BITS);
    end
    // Set after clear so an event in the clearing cycle survives
    flags_next = flags_next | set_vec;
    if (soft_reset) begin
      flags_next = `FLAGS_RESET;
    end
  end

  // Alarm flag register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_reg <= `FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Mask next state, all eight bits stored as written
  always_comb begin
    mask_next = mask_reg;
    if (mask_wr) begin
      mask_next = wr_byte;
    end
    if (soft_reset) begin
      mask_next = `MASK_RESET;
    end
  end

  // Mask register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_reg <= `MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // Lane flag next state
  always_comb begin
    lane_next = lane_reg;
    if (lane_wr) begin
      lane_next = lane_reg & ~wr_byte[LANES-1:0];
    end
    if (flags_wr && wr_byte[`BIT_FIFO]) begin
      lane_next = '0;
    end
    // A persisting lane error wins over both clears
    lane_next = lane_next | lane_set;
    if (soft_reset) begin
      lane_next = LANES'(`LANE_RESET);
    end
  end

  // Lane flag register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lane_reg <= LANES'(`LANE_RESET);
    end else begin
      lane_reg <= lane_next;
    end
  end

  // Control next state, soft reset bit clears itself
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next = wr_byte;
    end
    if (soft_reset) begin
      ctrl_next[`CTRL_BIT_SOFT_RESET] = 1'b0;
    end
  end

  // Control register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= `CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Link enable delay for the 64b66b start edge
  always_comb begin
    link_en_d_next = i_events.link_enable;
  end

  // Link enable delay register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link_en_d_reg <= 1'b0;
    end else begin
      link_en_d_reg <= link_en_d_next;
    end
  end

  // Write channel next state
  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    wst_next = wst_reg;
    unique case (wst_reg)
      W_IDLE: begin
        if (i_awvalid && o_awready) begin
          aw_got_next = 1'b1;
          awaddr_next = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
          w_got_next = 1'b1;
          wdata_next = i_wdata;
          wstrb_next = i_wstrb;
        end
        if (wr_fire) begin
          wst_next = W_RESP;
          aw_got_next = 1'b0;
          w_got_next = 1'b0;
          unique case (wr_idx)
            `FLAGS_IDX, `MASK_IDX, `LANE_IDX, `CTRL_IDX: bresp_next = `RESP_OKAY;
            `SUMMARY_IDX: bresp_next = `RESP_OKAY;
            default: bresp_next = `RESP_SLVERR;
          endcase
        end
      end
      W_RESP: begin
        if (i_bready) begin
          wst_next = W_IDLE;
        end
      end
    endcase
  end

  // Read channel next state
  always_comb begin
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    rst_next = rst_reg;
    unique case (rst_reg)
      R_IDLE: begin
        if (i_arvalid) begin
          rst_next = R_RESP;
          rresp_next = `RESP_OKAY;
          unique case (rd_idx)
            `SUMMARY_IDX: rdata_next = {31'h0, summary};
            `FLAGS_IDX: rdata_next = {24'h0, flags_reg};
            `MASK_IDX: rdata_next = {24'h0, mask_reg};
            `LANE_IDX: rdata_next = {{(32-LANES){1'b0}}, lane_reg};
            `CTRL_IDX: rdata_next = {24'h0, ctrl_reg};
            default: begin
              rdata_next = 32'h0;
              rresp_next = `RESP_SLVERR;
            end
          endcase
        end
      end
      R_RESP: begin
        if (i_rready) begin
          rst_next = R_IDLE;
        end
      end
    endcase
  end

  // Write channel registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 32'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bresp_reg <= 2'b00;
      wst_reg <= W_IDLE;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
      wst_reg <= wst_next;
    end
  end

  // Read channel registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 32'h0;
      rresp_reg <= 2'b00;
      rst_reg <= R_IDLE;
    end else begin
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      rst_reg <= rst_next;
    end
  end
endmodule : alarm_status_aggregator

// file: dv/alarm_status_aggregator_checker.sv
// Bus timing and alarm output checker
`timescale 1ns/10ps
module alarm_status_aggregator_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] i_araddr,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Response timing and hold
  property p_bv; i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid; endproperty
  a_bv: assert property (p_bv) else $error("write response late");
  property p_rv; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read response late");
  property p_bh; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_bh: assert property (p_bh) else $error("write response dropped");
  property p_rh; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_rh: assert property (p_rh) else $error("read data dropped");
  property p_ue; i_arvalid && o_arready && i_araddr[13:2] == 12'h0 |=> o_rresp == 2'b10; endproperty
  a_ue: assert property (p_ue) else $error("unmapped read not refused");
  property p_up; o_rvalid |-> o_rdata[31:8] == 24'h0; endproperty
  a_up: assert property (p_up) else $error("upper read bits set");
  // Alarm output
  property p_rst; $rose(i_rst_n) |-> !o_irq; endproperty
  a_rst: assert property (p_rst) else $error("alarm out of reset");
  property p_stk; o_irq && o_awready && !i_awvalid |=> o_irq; endproperty
  a_stk: assert property (p_stk) else $error("alarm dropped without write");
  c_wr: cover property (o_bvalid && i_bready);
  c_rd: cover property (o_rvalid && !i_rready);
  c_irq: cover property ($rose(o_irq));
endmodule : alarm_status_aggregator_checker
bind alarm_status_aggregator alarm_status_aggregator_checker alarm_status_aggregator_checker_i (
  .i_clk, .i_rst_n, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_bready,
  .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .o_irq);

// file: dv/alarm_status_aggregator_test.sv
// Self-checking bench of the alarm block
`timescale 1ns/10ps
`include "alarm_defs.svh"
module alarm_status_aggregator_test;
  import alarm_pkg::*;
  localparam logic [31:0] fa = `FLAGS_IDX * 4;
  localparam logic [31:0] ma = `MASK_IDX * 4;
  localparam logic [31:0] la = `LANE_IDX * 4;
  localparam logic [31:0] ca = `CTRL_IDX * 4;
  logic [7:0] ev_tab [7] = '{8'h80, 8'hd0, 8'hc8, 8'ha4, 8'ha2, 8'ha1, 8'ha0};
  int n_errors = 0;
  int check_count = 0;
  int k;
  logic [31:0] s = 32'hf034;
  logic [7:0] m, e;
  logic i_clk, i_rst_n, i_cal_status, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata;
  logic [3:0] i_wstrb;
  logic [7:0] i_lane_fifo_error, i_lane_active;
  alarm_events_t i_events;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, o_cal_status_pin;
  logic [1:0] o_bresp, o_rresp;
  alarm_status_aggregator alarm_status_aggregator_i (.i_clk, .i_rst_n, .i_events,
    .i_lane_fifo_error, .i_lane_active, .i_cal_status, .i_awvalid, .o_awready, .i_awaddr,
    .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
    .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .o_irq, .o_cal_status_pin);
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // Flags expected from one stimulus kind
  function automatic logic [7:0] expf(int kd, logic [7:0] act, logic [2:0] n);
    logic [7:0] b [7] = '{8'h08, 8'h08, 8'h08, 8'h04, 8'h01, 8'h10, 8'h20};
    return (kd == 6 && !act[n]) ? 8'h00 : b[kd];
  endfunction : expf
  task chk(input string nm, input logic [31:0] v, x);
    check_count++;
    if (v !== x) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, x, v);
    end
  endtask : chk
  task wr(input logic [31:0] a, input logic [7:0] x);
    i_awaddr <= a;
    i_wdata <= {24'h0, x};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    @(negedge i_clk);
    while (o_awready !== 1'b1 || o_wready !== 1'b1) @(negedge i_clk);
    @(posedge i_clk);
    i_awvalid <= 1'b0;
    i_wvalid <= 1'b0;
    if (s[0]) @(posedge i_clk);
    i_bready <= 1'b1;
    @(negedge i_clk);
    while (o_bvalid !== 1'b1) @(negedge i_clk);
    chk("bresp", o_bresp, `RESP_OKAY);
    @(posedge i_clk);
    i_bready <= 1'b0;
  endtask : wr
  task rd(input logic [31:0] a, input logic [7:0] x);
    logic [31:0] d;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    @(negedge i_clk);
    while (o_arready !== 1'b1) @(negedge i_clk);
    @(posedge i_clk);
    i_arvalid <= 1'b0;
    if (s[1]) @(posedge i_clk);
    i_rready <= 1'b1;
    @(negedge i_clk);
    while (o_rvalid !== 1'b1) @(negedge i_clk);
    d = o_rdata;
    chk("rresp", o_rresp, (a == 32'h0) ? `RESP_SLVERR : `RESP_OKAY);
    @(posedge i_clk);
    i_rready <= 1'b0;
    chk("rdata", d, {24'h0, x});
  endtask : rd
  task conclude;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // Watchdog
  initial begin
    #300000;
    n_errors++;
    conclude();
  end
  // Main sequence
  initial begin
    {i_rst_n, i_cal_status, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 7'h0;
    {i_awaddr, i_wdata, i_araddr} = 96'h0;
    {i_wstrb, i_lane_fifo_error, i_lane_active, i_events} = {4'h1, 8'h0, 8'hff, 8'ha0};
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    chk("irq", o_irq, 0);
    rd(fa, 8'h3f);
    rd(ma, 8'h3f);
    rd(la, 8'hff);
    rd(0, 8'h00);
    wr(ma, 8'h02);
    chk("irq", o_irq, 1);
    wr(fa, 8'hff);
    rd(fa, 8'h02);
    rd(la, 8'h00);
    chk("irq", o_irq, 0);
    // Random events under random masks
    repeat (16) begin
      s = lfsr(s);
      k = s % 7;
      m = s[23:16] & 8'h3d | 8'h02;
      i_lane_active <= s[31:24];
      wr(ma, m);
      i_events <= ev_tab[k];
      i_lane_fifo_error <= {7'h0, k == 6} << s[10:8];
      @(posedge i_clk);
      i_events <= 8'ha0;
      i_lane_fifo_error <= 8'h0;
      @(posedge i_clk);
      e = expf(k, s[31:24], s[10:8]);
      chk("irq", o_irq, |(e & ~m & 8'h3d));
      rd(fa, e | 8'h02);
      if (k == 6) rd(la, {7'h0, e[5]} << s[10:8]);
      wr(fa, 8'hff);
      rd(fa, 8'h02);
      rd(la, 8'h00);
    end
    // Held conditions against clears
    wr(ma, 8'h02);
    i_events <= 8'ha2;
    i_lane_fifo_error <= 8'h01;
    i_lane_active <= 8'hff;
    wr(la, 8'h01);
    wr(fa, 8'h21);
    rd(fa, 8'h23);
    rd(la, 8'h01);
    chk("pin", o_cal_status_pin, 0);
    wr(ca, 8'h02);
    chk("pin", o_cal_status_pin, 1);
    i_events <= 8'ha0;
    i_lane_fifo_error <= 8'h00;
    wr(ca, 8'h01);
    rd(ma, 8'h3f);
    rd(fa, 8'h3f);
    rd(la, 8'hff);
    conclude();
  end
endmodule : alarm_status_aggregator_test
